// ==== sleep_ctrl_consts.vh ====
// constants for the sleep entry and interrupt flag block
// assumes inclusion by bare name from the design file
`ifndef SLEEP_CTRL_CONSTS_VH
`define SLEEP_CTRL_CONSTS_VH

// register indices on the plain register port
`define ADDR_IRQ_CONTROL_MAIN   4'h0
`define ADDR_OPTION_CONFIG      4'h1
`define ADDR_PIE_A              4'h2
`define ADDR_PIE_B              4'h3
`define ADDR_PIE_C              4'h4
`define ADDR_PIR_A              4'h5
`define ADDR_PIR_B              4'h6
`define ADDR_PIR_C              4'h7
`define ADDR_PWR_STATUS         4'h8
`define ADDR_EVT_STATUS         4'h9
`define ADDR_EVT_MASK           4'hA

// implemented bit masks; all other positions read zero
`define MASK_PIE_A              8'hC3
`define MASK_PIE_B              8'h04
`define MASK_PIE_C              8'h03
`define MASK_PIR_A              8'hC3
`define MASK_PIR_B              8'h04
`define MASK_PIR_C              8'h03
`define MASK_PWR_STATUS         8'h03
`define MASK_EVT                8'h03

// field positions
`define BIT_GIE                 7
`define BIT_PERIPHERAL_IRQ_ENABLE                6
`define BIT_TO                  1
`define BIT_PD                  0
`define BIT_EVT_SLEEP           0
`define BIT_EVT_WAKE            1

// reset values
`define RST_BYTE                8'h00
`define RST_PWR_STATUS          8'h03
`define RST_WDT                 16'h0000
`define WDT_ONE                 16'h0001

`endif

// ==== sleep_ctrl.v ====
// sleep entry control, peripheral interrupt flag and enable registers
// assumes core, peripherals and firmware on one 25 MHz clock; wake sources
// and condition pulses are synchronous to ref_clk_in
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "sleep_ctrl_consts.vh"

module sleep_ctrl (
    input  wire        ref_clk_in,
    input  wire        rst_n_in,
    input  wire [3:0]  reg_addr_in,
    input  wire [7:0]  reg_wdata_in,
    input  wire        reg_wr_in,
    input  wire        reg_rd_in,
    output reg  [7:0]  reg_rdata_out,
    input  wire        sleep_instr_in,
    input  wire        core_irq_pending_in,
    input  wire        ext_wake_in,
    input  wire        wdt_enable_in,
    input  wire        wdt_tick_in,
    input  wire [7:0]  cond_a_in,
    input  wire [7:0]  cond_b_in,
    input  wire [7:0]  cond_c_in,
    input  wire [7:0]  pin_out_in,
    input  wire [7:0]  pin_oe_in,
    input  wire        timer1_src_slow_in,
    input  wire        adc_src_conv_osc_in,
    output wire        core_clk_en_out,
    output wire        asleep_out,
    output wire        slow_osc_run_out,
    output wire        timer1_run_out,
    output wire        adc_run_out,
    output wire [7:0]  pin_out_out,
    output wire [7:0]  pin_oe_out,
    output reg  [15:0] watchdog_counter_out,
    output wire        periph_irq_out,
    output wire        vector_irq_out,
    output wire        irq_out
);

// ==========================================================================
// state
// ==========================================================================
reg  [7:0]  irq_control_main_ff;
reg  [7:0]  option_config_ff;
reg  [7:0]  pie_ff [0:2];
reg  [7:0]  pir_ff [0:2];
reg  [7:0]  pwr_status_ff;
reg  [7:0]  evt_status_ff;
reg  [7:0]  evt_mask_ff;
reg         asleep_ff;
reg  [7:0]  pin_out_hold_ff;
reg  [7:0]  pin_oe_hold_ff;
reg  [15:0] nxt_wdt;

wire [7:0]  cond_all [0:2];
wire [7:0]  mask_pir [0:2];
wire [7:0]  mask_pie [0:2];
wire [3:0]  addr_pie [0:2];
wire [3:0]  addr_pir [0:2];
wire [2:0]  src_pending;

assign cond_all[0] = cond_a_in;
assign cond_all[1] = cond_b_in;
assign cond_all[2] = cond_c_in;
assign mask_pir[0] = `MASK_PIR_A;
assign mask_pir[1] = `MASK_PIR_B;
assign mask_pir[2] = `MASK_PIR_C;
assign mask_pie[0] = `MASK_PIE_A;
assign mask_pie[1] = `MASK_PIE_B;
assign mask_pie[2] = `MASK_PIE_C;
assign addr_pie[0] = `ADDR_PIE_A;
assign addr_pie[1] = `ADDR_PIE_B;
assign addr_pie[2] = `ADDR_PIE_C;
assign addr_pir[0] = `ADDR_PIR_A;
assign addr_pir[1] = `ADDR_PIR_B;
assign addr_pir[2] = `ADDR_PIR_C;

// ==========================================================================
// peripheral flag and enable registers
// ==========================================================================
genvar gi;
generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_periph
        always @(posedge ref_clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
                pie_ff[gi] <= `RST_BYTE;
                pir_ff[gi] <= `RST_BYTE;
            end else begin
                if (reg_wr_in && reg_addr_in == addr_pie[gi]) begin
                    pie_ff[gi] <= reg_wdata_in & mask_pie[gi];
                end
                // a condition in the write cycle still sets its flag
                if (reg_wr_in && reg_addr_in == addr_pir[gi]) begin
                    pir_ff[gi] <= (reg_wdata_in | cond_all[gi]) & mask_pir[gi];
                end else begin
                    pir_ff[gi] <= (pir_ff[gi] | cond_all[gi]) & mask_pir[gi];
                end
            end
        end
        assign src_pending[gi] = |(pir_ff[gi] & pie_ff[gi]);
    end
endgenerate

// ==========================================================================
// requests and wake
// ==========================================================================
wire any_periph    = |src_pending;
assign periph_irq_out = any_periph & irq_control_main_ff[`BIT_PERIPHERAL_IRQ_ENABLE];
wire any_enabled   = periph_irq_out | core_irq_pending_in;
assign vector_irq_out = any_enabled & irq_control_main_ff[`BIT_GIE];

// global enable deliberately not part of the wake term
wire wake_evt  = asleep_ff & (any_enabled | ext_wake_in);
// enter only on the instruction, and not with an enabled request pending
wire sleep_evt = sleep_instr_in & ~asleep_ff & ~any_enabled;

// ==========================================================================
// control registers and power state
// ==========================================================================
always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        irq_control_main_ff <= `RST_BYTE;
        option_config_ff    <= `RST_BYTE;
        evt_mask_ff         <= `RST_BYTE;
        pwr_status_ff       <= `RST_PWR_STATUS;
        asleep_ff           <= 1'b0;
        pin_out_hold_ff     <= `RST_BYTE;
        pin_oe_hold_ff      <= `RST_BYTE;
    end else begin
        if (reg_wr_in && reg_addr_in == `ADDR_IRQ_CONTROL_MAIN) begin
            irq_control_main_ff <= reg_wdata_in;
        end
        if (reg_wr_in && reg_addr_in == `ADDR_OPTION_CONFIG) begin
            option_config_ff <= reg_wdata_in;
        end
        if (reg_wr_in && reg_addr_in == `ADDR_EVT_MASK) begin
            evt_mask_ff <= reg_wdata_in & `MASK_EVT;
        end
        if (sleep_evt) begin
            pwr_status_ff[`BIT_PD] <= 1'b0;
            pwr_status_ff[`BIT_TO] <= 1'b1;
            asleep_ff              <= 1'b1;
            pin_out_hold_ff        <= pin_out_in;
            pin_oe_hold_ff         <= pin_oe_in;
        end else if (wake_evt) begin
            asleep_ff <= 1'b0;
        end
    end
end

// ==========================================================================
// watchdog counter
// ==========================================================================
// the counter is only cleared here; it never issues a reset of its own
always @* begin
    nxt_wdt = watchdog_counter_out;
    if (sleep_evt || wake_evt) begin
        nxt_wdt = `RST_WDT;
    end else if (wdt_enable_in && wdt_tick_in) begin
        nxt_wdt = watchdog_counter_out + `WDT_ONE;
    end
end

always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        watchdog_counter_out <= `RST_WDT;
    end else begin
        watchdog_counter_out <= nxt_wdt;
    end
end

// ==========================================================================
// sleep-time outputs
// ==========================================================================
assign asleep_out       = asleep_ff;
assign core_clk_en_out  = ~asleep_ff;
assign slow_osc_run_out = 1'b1;
assign timer1_run_out   = ~asleep_ff | timer1_src_slow_in;
assign adc_run_out      = ~asleep_ff | adc_src_conv_osc_in;
assign pin_out_out      = asleep_ff ? pin_out_hold_ff : pin_out_in;
assign pin_oe_out       = asleep_ff ? pin_oe_hold_ff : pin_oe_in;
// reset inputs are not routed here; sleep cannot mask them

// ==========================================================================
// event status, write one to clear, set wins
// ==========================================================================
always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        evt_status_ff <= `RST_BYTE;
    end else begin
        if (reg_wr_in && reg_addr_in == `ADDR_EVT_STATUS) begin
            evt_status_ff <= evt_status_ff & ~reg_wdata_in & `MASK_EVT;
        end
        if (sleep_evt) begin
            evt_status_ff[`BIT_EVT_SLEEP] <= 1'b1;
        end
        if (wake_evt) begin
            evt_status_ff[`BIT_EVT_WAKE] <= 1'b1;
        end
    end
end

assign irq_out = |(evt_status_ff & evt_mask_ff);

// ==========================================================================
// read port
// ==========================================================================
reg [7:0] nxt_rdata;
always @* begin
    nxt_rdata = `RST_BYTE;
    case (reg_addr_in)
        `ADDR_IRQ_CONTROL_MAIN: nxt_rdata = irq_control_main_ff;
        `ADDR_OPTION_CONFIG:    nxt_rdata = option_config_ff;
        `ADDR_PIE_A:            nxt_rdata = pie_ff[0];
        `ADDR_PIE_B:            nxt_rdata = pie_ff[1];
        `ADDR_PIE_C:            nxt_rdata = pie_ff[2];
        `ADDR_PIR_A:            nxt_rdata = pir_ff[0];
        `ADDR_PIR_B:            nxt_rdata = pir_ff[1];
        `ADDR_PIR_C:            nxt_rdata = pir_ff[2];
        `ADDR_PWR_STATUS:       nxt_rdata = pwr_status_ff & `MASK_PWR_STATUS;
        `ADDR_EVT_STATUS:       nxt_rdata = evt_status_ff;
        `ADDR_EVT_MASK:         nxt_rdata = evt_mask_ff;
        default:                nxt_rdata = `RST_BYTE;
    endcase
end

// read data stands only in the cycle after the strobe
always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        reg_rdata_out <= `RST_BYTE;
    end else if (reg_rd_in) begin
        reg_rdata_out <= nxt_rdata;
    end else begin
        reg_rdata_out <= `RST_BYTE;
    end
end

endmodule
`default_nettype wire

// ==== sleep_ctrl_sva.sv ====
// checker: sleep entry, wake, pin hold and read-back rules
// assumes the port list of sleep_ctrl and a single clock
`timescale 1ns/1ps
`default_nettype none
module sleep_ctrl_sva (
    input wire logic        ref_clk_in,
    input wire logic        rst_n_in,
    input wire logic [3:0]  reg_addr_in,
    input wire logic        reg_rd_in,
    input wire logic [7:0]  reg_rdata_out,
    input wire logic        sleep_instr_in,
    input wire logic        core_irq_pending_in,
    input wire logic        ext_wake_in,
    input wire logic        core_clk_en_out,
    input wire logic        asleep_out,
    input wire logic [7:0]  pin_out_out,
    input wire logic [7:0]  pin_oe_out,
    input wire logic [15:0] watchdog_counter_out,
    input wire logic        periph_irq_out,
    input wire logic        vector_irq_out
);
// ==========================================
// properties
default clocking @(posedge ref_clk_in); endclocking
default disable iff (!rst_n_in);
wire logic pend = periph_irq_out | core_irq_pending_in;
property p_entry;
    sleep_instr_in && !asleep_out && !pend |=> asleep_out && watchdog_counter_out == 16'h0000;
endproperty
a_entry: assert property (p_entry) else $error("bad sleep entry");
property p_noop;
    sleep_instr_in && !asleep_out && pend |=> !asleep_out;
endproperty
a_noop: assert property (p_noop) else $error("sleep not ignored");
property p_stay;
    !asleep_out && !sleep_instr_in |=> !asleep_out;
endproperty
a_stay: assert property (p_stay) else $error("sleep without instruction");
property p_gate;
    asleep_out |-> !core_clk_en_out;
endproperty
a_gate: assert property (p_gate) else $error("core clock runs asleep");
property p_wake;
    asleep_out && (pend || ext_wake_in) |=> !asleep_out && watchdog_counter_out == 16'h0000;
endproperty
a_wake: assert property (p_wake) else $error("bad wake");
property p_hold;
    asleep_out && $past(asleep_out) |-> $stable(pin_out_out) && $stable(pin_oe_out);
endproperty
a_hold: assert property (p_hold) else $error("pins moved asleep");
property p_vec;
    vector_irq_out |-> pend;
endproperty
a_vec: assert property (p_vec) else $error("vector without request");
property p_rdzero;
    reg_rd_in && reg_addr_in > 4'hA |=> reg_rdata_out == 8'h00;
endproperty
a_rdzero: assert property (p_rdzero) else $error("unmapped read nonzero");
c_entry: cover property (sleep_instr_in && !asleep_out && !pend);
c_noop: cover property (sleep_instr_in && !asleep_out && pend);
c_wake: cover property (asleep_out ##1 !asleep_out);
endmodule
bind sleep_ctrl sleep_ctrl_sva chk_u (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .reg_addr_in(reg_addr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .sleep_instr_in(sleep_instr_in), .core_irq_pending_in(core_irq_pending_in),
    .ext_wake_in(ext_wake_in), .core_clk_en_out(core_clk_en_out), .asleep_out(asleep_out),
    .pin_out_out(pin_out_out), .pin_oe_out(pin_oe_out),
    .watchdog_counter_out(watchdog_counter_out), .periph_irq_out(periph_irq_out),
    .vector_irq_out(vector_irq_out));
`default_nettype wire

// ==== periph_model.sv ====
// stand-in for peripherals and core: condition pulses, ticks, pin drive
// assumes one-cycle requests from the bench, synchronous to clk_in
`timescale 1ns/1ps
`default_nettype none
module periph_model (
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic [23:0] fire_in,
    output logic      [23:0] cond_out,
    output logic             tick_out,
    output logic      [7:0]  pin_out_out,
    output logic      [7:0]  pin_oe_out
);
// ==========================================
// behaviour
logic [1:0] div_ff;
// pins move every cycle so a hold that slips shows up
always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        div_ff <= 2'h0;
        cond_out <= 24'h000000;
        tick_out <= 1'b0;
        pin_out_out <= 8'h5A;
        pin_oe_out <= 8'h00;
    end else begin
        div_ff <= div_ff + 2'h1;
        cond_out <= fire_in;
        tick_out <= (div_ff == 2'h3);
        pin_out_out <= ~pin_out_out;
        pin_oe_out <= pin_oe_out + 8'h01;
    end
end
endmodule
`default_nettype wire

// ==== sleep_ctrl_bench.sv ====
// testbench for sleep_ctrl: register, flag, sleep and wake sequences
// assumes the constants header and periph_model alongside
`timescale 1ns/1ps
`default_nettype none
`include "sleep_ctrl_consts.vh"
module sleep_ctrl_bench;
logic        ref_clk_in = 1'b0;
logic        rst_n_in = 1'b0;
logic [3:0]  addr = 4'h0;
logic [7:0]  wdata = 8'h00;
logic        wr_s = 1'b0;
logic        rd_s = 1'b0;
logic        slp = 1'b0;
logic        extw = 1'b0;
logic        wden = 1'b0;
logic        cip = 1'b0;
logic        t1s = 1'b1;
logic        adcs = 1'b1;
wire         t1r, adr, slw, pirq;
logic [23:0] fire = 24'h000000;
wire  [23:0] cond;
wire  [7:0]  rdata, po, poe, mpo, mpoe;
wire  [15:0] wdt;
wire         tick, clk_en, asleep, virq, irq;
logic [15:0] held;
logic [7:0]  msk [8] = '{8'h00, 8'h00, `MASK_PIE_A, `MASK_PIE_B, `MASK_PIE_C,
                         `MASK_PIR_A, `MASK_PIR_B, `MASK_PIR_C};
int          err_total = 0;
int          tests_run = 0;
always #20 ref_clk_in = ~ref_clk_in;
periph_model pm_u (.clk_in(ref_clk_in), .rst_n_in(rst_n_in), .fire_in(fire), .cond_out(cond),
    .tick_out(tick), .pin_out_out(mpo), .pin_oe_out(mpoe));
sleep_ctrl dut_u (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata),
    .sleep_instr_in(slp), .core_irq_pending_in(cip), .ext_wake_in(extw),
    .wdt_enable_in(wden), .wdt_tick_in(tick), .cond_a_in(cond[7:0]), .cond_b_in(cond[15:8]),
    .cond_c_in(cond[23:16]), .pin_out_in(mpo), .pin_oe_in(mpoe), .timer1_src_slow_in(t1s),
    .adc_src_conv_osc_in(adcs), .core_clk_en_out(clk_en), .asleep_out(asleep),
    .slow_osc_run_out(slw), .timer1_run_out(t1r), .adc_run_out(adr), .pin_out_out(po),
    .pin_oe_out(poe), .watchdog_counter_out(wdt), .periph_irq_out(pirq), .vector_irq_out(virq),
    .irq_out(irq));
// ==========================================
// tasks
task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
        err_total++;
        $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
endtask
task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge ref_clk_in);
    wr_s <= 1'b0;
endtask
task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge ref_clk_in);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge ref_clk_in);
    rd_s <= 1'b0;
    #1 chk({8'h00, rdata}, {8'h00, e});
endtask
// one-cycle condition request and/or sleep instruction
task automatic pulse(input logic [23:0] f, input logic s);
    @(posedge ref_clk_in);
    fire <= f;
    slp <= s;
    @(posedge ref_clk_in);
    fire <= 24'h000000;
    slp <= 1'b0;
endtask
task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
        $display("NO MISMATCHES");
    end else begin
        $display("MISMATCHES SEEN");
    end
    $finish;
endtask
// ==========================================
// sequences
initial begin
    repeat (2) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    for (int i = 0; i < 16; i++) rd(i[3:0], (i == 8) ? `RST_PWR_STATUS : `RST_BYTE);
    for (int i = 2; i < 8; i++) begin
        wr(i[3:0], 8'hFF);
        rd(i[3:0], msk[i]);
        wr(i[3:0], 8'h00);
        rd(i[3:0], 8'h00);
    end
    pulse(24'hFFFFFF, 1'b0);
    for (int i = 5; i < 8; i++) rd(i[3:0], msk[i]);
    for (int i = 5; i < 8; i++) wr(i[3:0], 8'h00);
    wr(`ADDR_EVT_MASK, 8'h03);
    wr(`ADDR_PIE_A, 8'h01);
    wr(`ADDR_IRQ_CONTROL_MAIN, 8'h40);
    wden <= 1'b1;
    pulse(24'h000000, 1'b1);
    #1 chk({clk_en, asleep, wdt[13:0]}, 16'h4000);
    chk({15'h0000, irq}, 16'h0001);
    held = {poe, po};
    rd(`ADDR_PWR_STATUS, 8'h02);
    repeat (5) @(posedge ref_clk_in);
    #1 chk({poe, po}, held);
    chk({13'h0000, t1r, adr, slw}, 16'h0007);
    @(posedge ref_clk_in);
    t1s <= 1'b0;
    adcs <= 1'b0;
    #1 chk({13'h0000, t1r, adr, slw}, 16'h0001);
    chk({15'h0000, wdt != 16'h0000}, 16'h0001);
    wr(`ADDR_EVT_MASK, 8'h00);
    #1 chk({15'h0000, irq}, 16'h0000);
    pulse(24'h000001, 1'b0);
    repeat (2) @(posedge ref_clk_in);
    #1 chk({asleep, virq, wdt[13:0]}, 16'h0000);
    chk({15'h0000, pirq}, 16'h0001);
    wr(`ADDR_IRQ_CONTROL_MAIN, 8'hC0);
    #1 chk({15'h0000, virq}, 16'h0001);
    rd(`ADDR_EVT_STATUS, 8'h03);
    wr(`ADDR_EVT_STATUS, 8'h03);
    pulse(24'h000000, 1'b1);
    #1 chk({15'h0000, asleep}, 16'h0000);
    rd(`ADDR_EVT_STATUS, 8'h00);
    wr(`ADDR_PIR_A, 8'h00);
    pulse(24'h000000, 1'b1);
    extw <= 1'b1;
    @(posedge ref_clk_in);
    extw <= 1'b0;
    #1 chk({asleep, 1'b0, wdt[13:0]}, 16'h0000);
    @(posedge ref_clk_in);
    cip <= 1'b1;
    pulse(24'h000000, 1'b1);
    #1 chk({15'h0000, asleep}, 16'h0000);
    rd(`ADDR_PWR_STATUS, 8'h02);
    @(posedge ref_clk_in);
    cip <= 1'b0;
    complete_run();
end
initial begin
    repeat (3000) @(posedge ref_clk_in);
    err_total++;
    complete_run();
end
endmodule
`default_nettype wire
